/* File: rtl/bsipc_top.sv */
// Byte-split I/O port sequencer: word, byte and bit-I/O bus cycles
`timescale 1ns/10ps
module bsipc_top (
    // Clock and reset
    input  wire logic                 I_SYS_CLK,
    input  wire logic                 I_SYS_RST,
    // CPU request side
    input  wire logic                 I_CPU_REQ,
    input  wire bsipc_pkg::bsipc_op_t I_CPU_OP,
    input  wire logic [15:0]          I_CPU_ADDR,
    input  wire logic [15:0]          I_CPU_WDATA,
    input  wire logic                 I_CPU_BYTE_HIGH,
    input  wire logic                 I_CPU_BIT,
    // CPU answer side
    output logic                      O_CPU_READY,
    output logic                      O_CPU_DONE,
    output logic [15:0]               O_CPU_RDATA,
    output logic                      O_CPU_BIT_IN,
    // Port address and strobes
    output logic [14:0]               O_ADDR,
    output logic                      O_LSB_ADDRESS_OR_BIT_OUT,
    output logic                      O_MEMORY_CYCLE_ENABLE_N,
    output logic                      O_DATA_INPUT_STROBE,
    output logic                      O_WRITE_STROBE_N,
    output logic                      O_BLOCK_ENABLE_N,
    output logic                      O_BIT_IO_CLOCK_N,
    // Mapped device selects
    output logic [7:0]                O_MEMORY_MAPPED_DEVICE_N,
    output logic                      O_SOUND_BLOCK_ENABLE_N,
    // Byte data bus, two-way
    input  wire logic [7:0]           I_DATA,
    output logic [7:0]                O_DATA,
    output logic                      O_DATA_OE,
    // Bit-I/O input pin
    input  wire logic                 I_BIT_IO_INPUT
);
    import bsipc_pkg::*;

    typedef struct packed {
        bsipc_state_t state;
        bsipc_op_t    op;
        logic [6:0]   cnt;
        logic [15:0]  addr;
        logic [15:0]  wdata;
        logic [15:0]  rword;
        logic         byte_high;
        logic         bit_val;
        logic         memory_cycle_enable_n_n;
        logic         data_input_strobe;
        logic         we_n;
        logic         mbe_n;
        logic         bclk_n;
        logic         lsb;
        logic         data_oe;
        logic [7:0]   dout;
        logic [7:0]   mmd_sel_n;
        logic         done;
        logic [15:0]  rdata;
        logic         bit_in;
    } bsipc_st_t;

    localparam bsipc_st_t RESET_ST = '{
        state:     ST_IDLE,
        op:        OP_READ,
        cnt:       7'h00,
        addr:      16'h0000,
        wdata:     16'h0000,
        rword:     16'h0000,
        byte_high: 1'b0,
        bit_val:   1'b0,
        memory_cycle_enable_n_n:   1'b1,
        data_input_strobe:      1'b0,
        we_n:      1'b1,
        mbe_n:     1'b1,
        bclk_n:    1'b1,
        lsb:       1'b0,
        data_oe:   1'b0,
        dout:      8'h00,
        mmd_sel_n: 8'hff,
        done:      1'b0,
        rdata:     16'h0000,
        bit_in:    1'b0
    };

    bsipc_st_t            q;
    bsipc_st_t            d;
    logic [MMD_BLOCKS-1:0] blk_hit;
    logic [7:0]           bus_clean;
    logic                 bit_clean;

    // Pin synchroniser for data bus and bit input
    bsipc_sync_if sif ();
    assign sif.raw = {I_BIT_IO_INPUT, I_DATA};
    assign bus_clean = sif.clean[7:0];
    assign bit_clean = sif.clean[8];

    bsipc_pin_sync u_sync (
        .i_clk (I_SYS_CLK),
        .i_rst (I_SYS_RST),
        .sif   (sif)
    );

    // 1K block decode inside mapped device space, mirrors kept
    genvar gi;
    generate
        for (gi = 0; gi < MMD_BLOCKS; gi = gi + 1) begin : g_blk
            assign blk_hit[gi] = (q.addr[15:13] == MMD_REGION) &&
                                 (q.addr[12:10] == 3'(gi));
        end
    endgenerate

    // Sequencer next state
    always_comb begin
        logic [6:0] nxt;
        logic [6:0] bo;
        logic       first;
        nxt   = 7'h00;
        bo    = 7'h00;
        first = 1'b0;
        d     = q;
        nxt   = q.cnt + 7'h01;
        first = (nxt < BYTE_CLKS);
        bo    = first ? nxt : 7'(nxt - BYTE_CLKS);
        // Idle pin levels unless a state drives them
        d.done      = 1'b0;
        d.memory_cycle_enable_n_n   = 1'b1;
        d.data_input_strobe      = 1'b0;
        d.we_n      = 1'b1;
        d.mbe_n     = 1'b1;
        d.bclk_n    = 1'b1;
        d.data_oe   = 1'b0;
        d.mmd_sel_n = 8'hff;
        case (q.state)
            ST_IDLE: begin
                if (I_CPU_REQ) begin
                    d.addr      = I_CPU_ADDR;
                    d.op        = I_CPU_OP;
                    d.wdata     = I_CPU_WDATA;
                    d.byte_high = I_CPU_BYTE_HIGH;
                    d.bit_val   = I_CPU_BIT;
                    d.cnt       = 7'h00;
                    case (I_CPU_OP)
                        OP_READ, OP_WRITE_WORD, OP_WRITE_BYTE: begin
                            if (I_CPU_ADDR[15:13] == CART_REGION) begin
                                // Cartridge space refused at once
                                d.done  = 1'b1;
                                d.rdata = REFUSED_DATA;
                            end else begin
                                // Every access opens with a read
                                d.state   = ST_READ;
                                d.memory_cycle_enable_n_n = 1'b0;
                                d.data_input_strobe    = 1'b1;
                                d.lsb     = 1'b1;
                            end
                        end
                        OP_BIT_OUT: begin
                            d.state = ST_BIT_OUT;
                            d.lsb   = I_CPU_BIT;
                        end
                        OP_BIT_IN: begin
                            d.state = ST_BIT_IN;
                        end
                        default: begin
                            d.state = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_READ: begin
                d.cnt = nxt;
                if (nxt < WORD_CLKS) begin
                    d.memory_cycle_enable_n_n   = 1'b0;
                    d.data_input_strobe      = 1'b1;
                    d.lsb       = first;
                    d.mmd_sel_n = ~blk_hit;
                    // Held low across both bytes once settled
                    d.mbe_n = !((q.addr[15:13] == EXT_BLOCK_REGION) &&
                                (nxt >= SETTLE_CLKS));
                end
                // Each byte spans three cycles with its wait state
                if (q.cnt == READ_LO_OFS) begin
                    d.rword[7:0] = bus_clean;
                end
                if (q.cnt == READ_HI_OFS) begin
                    d.rword[15:8] = bus_clean;
                end
                if (q.cnt == 7'(PRESENT_OFS - 7'h01)) begin
                    d.rdata = q.rword;
                    d.done  = (q.op == OP_READ);
                end
                if (q.cnt == 7'(WORD_CLKS - 7'h01)) begin
                    d.cnt = 7'h00;
                    if (q.op == OP_READ) begin
                        d.state = ST_IDLE;
                    end else begin
                        d.state = ST_ALU;
                        if (q.op == OP_WRITE_BYTE) begin
                            // Keep the untouched byte of the read word
                            d.wdata = q.byte_high ?
                                {q.wdata[15:8], q.rword[7:0]} :
                                {q.rword[15:8], q.wdata[7:0]};
                        end
                    end
                end
            end
            ST_ALU: begin
                d.cnt = nxt;
                if (q.cnt == 7'(CYC_CLKS - 7'h01)) begin
                    d.cnt     = 7'h00;
                    d.state   = ST_WRITE;
                    d.memory_cycle_enable_n_n = 1'b0;
                    d.lsb     = 1'b1;
                    d.data_oe = 1'b1;
                    d.dout    = q.wdata[7:0];
                end
            end
            ST_WRITE: begin
                d.cnt = nxt;
                if (nxt < WORD_CLKS) begin
                    // Two identical byte writes
                    d.memory_cycle_enable_n_n   = 1'b0;
                    d.data_oe   = 1'b1;
                    d.lsb       = first;
                    d.dout      = first ? q.wdata[7:0] : q.wdata[15:8];
                    d.mmd_sel_n = ~blk_hit;
                    d.we_n  = !((bo >= SETTLE_CLKS) &&
                                (bo < WE_END));
                    d.mbe_n = !((q.addr[15:13] == EXT_BLOCK_REGION) &&
                                (nxt >= SETTLE_CLKS));
                end
                if (q.cnt == 7'(WORD_CLKS - 7'h01)) begin
                    d.cnt   = 7'h00;
                    d.state = ST_IDLE;
                    d.done  = 1'b1;
                end
            end
            ST_BIT_OUT: begin
                d.cnt = nxt;
                d.lsb = q.bit_val;
                // Short clock after settling, in the second phase of cycle two
                d.bclk_n = !((nxt >= BITCLK_OFS) &&
                    (nxt < 7'(BITCLK_OFS + BITCLK_CLKS)));
                if (q.cnt == 7'(BIT_CLKS - 7'h01)) begin
                    d.cnt   = 7'h00;
                    d.state = ST_IDLE;
                    d.done  = 1'b1;
                end
            end
            ST_BIT_IN: begin
                d.cnt = nxt;
                if (q.cnt == BITIN_OFS) begin
                    d.bit_in = bit_clean;
                end
                if (q.cnt == 7'(BIT_CLKS - 7'h01)) begin
                    d.cnt   = 7'h00;
                    d.state = ST_IDLE;
                    d.done  = 1'b1;
                end
            end
            default: begin
                d = RESET_ST;
            end
        endcase
    end

    // State register
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            q <= RESET_ST;
        end else begin
            q <= d;
        end
    end

    // CPU side
    assign O_CPU_READY  = (q.state == ST_IDLE);
    assign O_CPU_DONE   = q.done;
    assign O_CPU_RDATA  = q.rdata;
    assign O_CPU_BIT_IN = q.bit_in;

    // Port pins, bit address on lines 0..14
    assign O_ADDR                   = q.addr[15:1];
    assign O_LSB_ADDRESS_OR_BIT_OUT = q.lsb;
    assign O_MEMORY_CYCLE_ENABLE_N  = q.memory_cycle_enable_n_n;
    assign O_DATA_INPUT_STROBE      = q.data_input_strobe;
    assign O_WRITE_STROBE_N         = q.we_n;
    assign O_BLOCK_ENABLE_N         = q.mbe_n;
    assign O_BIT_IO_CLOCK_N         = q.bclk_n;
    assign O_MEMORY_MAPPED_DEVICE_N = q.mmd_sel_n;
    assign O_SOUND_BLOCK_ENABLE_N   = q.mmd_sel_n[SOUND_IDX];
    assign O_DATA                   = q.dout;
    assign O_DATA_OE                = q.data_oe;

endmodule

/* File: rtl/bsipc_pkg.sv */
// Constants and types for the byte-split I/O port sequencer
package bsipc_pkg;

    // System clock period
    localparam int CLK_NS       = 20;

    // CPU clock cycle and its four phases
    localparam int CPU_CYCLE_NS = 333;
    localparam logic [6:0] PHASE_CLKS = 7'(CPU_CYCLE_NS / (4 * CLK_NS));
    localparam logic [6:0] CYC_CLKS   = 7'(4 * (CPU_CYCLE_NS / (4 * CLK_NS)));

    // Address settling before any sampled strobe, rounded up
    localparam int SETTLE_NS    = 100;
    localparam logic [6:0] SETTLE_CLKS =
        7'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

    // Write strobe width, typical figure, rounded down
    localparam int WE_NS        = 666;
    localparam logic [6:0] WE_CLKS = 7'(WE_NS / CLK_NS);
    localparam logic [6:0] WE_END  = 7'(SETTLE_CLKS + WE_CLKS);

    // Bit-I/O clock pulse, longest width, rounded down
    localparam int BITCLK_NS    = 63;
    localparam logic [6:0] BITCLK_CLKS = 7'(BITCLK_NS / CLK_NS);

    // Sequence lengths and event offsets, in system clocks
    localparam logic [6:0] BYTE_CLKS   = 7'(3 * CYC_CLKS);
    localparam logic [6:0] WORD_CLKS   = 7'(6 * CYC_CLKS);
    localparam logic [6:0] BIT_CLKS    = 7'(2 * CYC_CLKS);
    localparam logic [6:0] READ_LO_OFS = 7'(3 * CYC_CLKS - 4);
    localparam logic [6:0] READ_HI_OFS = 7'(5 * CYC_CLKS - 2);
    localparam logic [6:0] PRESENT_OFS = 7'(5 * CYC_CLKS);
    localparam logic [6:0] BITCLK_OFS  = 7'(CYC_CLKS + PHASE_CLKS);
    localparam logic [6:0] BITIN_OFS   = 7'(CYC_CLKS);

    // Address regions by top three bits
    localparam logic [2:0] EXT_BLOCK_REGION = 3'h2;
    localparam logic [2:0] CART_REGION      = 3'h3;
    localparam logic [2:0] MMD_REGION       = 3'h4;
    localparam int         MMD_BLOCKS       = 8;
    localparam logic [2:0] SOUND_IDX        = 3'h1;

    // Read data returned for a refused access
    localparam logic [15:0] REFUSED_DATA = 16'hffff;

    // Width of the synchronised pin group: data byte plus bit input
    localparam int SYNC_W = 9;

    // CPU operations
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE_WORD,
        OP_WRITE_BYTE,
        OP_BIT_OUT,
        OP_BIT_IN
    } bsipc_op_t;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_ALU,
        ST_WRITE,
        ST_BIT_OUT,
        ST_BIT_IN
    } bsipc_state_t;

endpackage

/* File: rtl/bsipc_sync_if.sv */
// Carrier between the sequencer and its pin synchroniser
`timescale 1ns/10ps
interface bsipc_sync_if;
    logic [bsipc_pkg::SYNC_W-1:0] raw;
    logic [bsipc_pkg::SYNC_W-1:0] clean;

    modport user (output raw, input clean);
    modport syncer (input raw, output clean);
endinterface

/* File: rtl/bsipc_pin_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module bsipc_pin_sync (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // Pin group
    bsipc_sync_if.syncer     sif
);
    import bsipc_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] clean;
    } bsipc_sync_st_t;

    bsipc_sync_st_t    q;
    bsipc_sync_st_t    d;
    logic [SYNC_W-1:0] clean_d;

    // A change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_bit
            assign clean_d[gi] = (q.s2[gi] == q.s3[gi]) ? q.s2[gi]
                                                          : q.clean[gi];
        end
    endgenerate

    // Next state
    always_comb begin
        d       = q;
        d.s1    = sif.raw;
        d.s2    = q.s1;
        d.s3    = q.s2;
        d.clean = clean_d;
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sif.clean = q.clean;

endmodule

/* File: bench/bsipc_properties.sv */
// Concurrent checks on the sequencer's port pins
`timescale 1ns/10ps
module bsipc_properties
    import bsipc_pkg::*;
(
    // Clock and reset
    input wire logic        I_SYS_CLK,
    input wire logic        I_SYS_RST,
    // Watched outputs
    input wire logic        O_CPU_DONE,
    input wire logic [14:0] O_ADDR,
    input wire logic        O_LSB_ADDRESS_OR_BIT_OUT,
    input wire logic        O_MEMORY_CYCLE_ENABLE_N,
    input wire logic        O_DATA_INPUT_STROBE,
    input wire logic        O_WRITE_STROBE_N,
    input wire logic        O_BLOCK_ENABLE_N,
    input wire logic        O_BIT_IO_CLOCK_N,
    input wire logic [7:0]  O_MEMORY_MAPPED_DEVICE_N,
    input wire logic        O_SOUND_BLOCK_ENABLE_N,
    input wire logic        O_DATA_OE
);
    // Block enable stays low over both bytes of a word
    localparam int MBE_LOW = 91;
    logic [6:0] we_cnt_q;
    logic [6:0] bc_cnt_q;
    logic [6:0] mbe_cnt_q;

    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);

    // Length of the current low stretch of each strobe
    always_ff @(posedge I_SYS_CLK) begin
        we_cnt_q  <= O_WRITE_STROBE_N ? 7'h00 : we_cnt_q + 7'h01;
        bc_cnt_q  <= O_BIT_IO_CLOCK_N ? 7'h00 : bc_cnt_q + 7'h01;
        mbe_cnt_q <= O_BLOCK_ENABLE_N ? 7'h00 : mbe_cnt_q + 7'h01;
    end

    read_start_a: assert property (
        $rose(O_DATA_INPUT_STROBE) |->
        !O_MEMORY_CYCLE_ENABLE_N && O_WRITE_STROBE_N)
        else $error("read start pins wrong");
    blk_settle_a: assert property (
        $fell(O_BLOCK_ENABLE_N) |->
        $past(O_MEMORY_CYCLE_ENABLE_N, 5) == 1'b0 &&
        $past(O_MEMORY_CYCLE_ENABLE_N, 6) == 1'b1)
        else $error("block enable not five clocks after start");
    blk_region_a: assert property (!O_BLOCK_ENABLE_N |->
        O_ADDR[14:12] == EXT_BLOCK_REGION)
        else $error("block enable outside its region");
    blk_hold_a: assert property ($rose(O_BLOCK_ENABLE_N) |->
        mbe_cnt_q == MBE_LOW)
        else $error("block enable low for wrong span");
    we_width_a: assert property ($rose(O_WRITE_STROBE_N) |->
        we_cnt_q == WE_CLKS)
        else $error("write strobe width wrong");
    we_guard_a: assert property (!O_WRITE_STROBE_N |->
        O_DATA_OE && !O_MEMORY_CYCLE_ENABLE_N && !O_DATA_INPUT_STROBE)
        else $error("write strobe outside a write");
    byte_order_a: assert property (
        $fell(O_MEMORY_CYCLE_ENABLE_N) |->
        O_LSB_ADDRESS_OR_BIT_OUT ##48 !O_LSB_ADDRESS_OR_BIT_OUT)
        else $error("byte order or lsb toggle wrong");
    bit_clk_a: assert property ($rose(O_BIT_IO_CLOCK_N) |->
        bc_cnt_q == BITCLK_CLKS && O_MEMORY_CYCLE_ENABLE_N)
        else $error("bit clock pulse wrong");
    read_done_a: assert property (
        O_CPU_DONE && O_DATA_INPUT_STROBE |->
        $past(O_MEMORY_CYCLE_ENABLE_N, 81) &&
        !$past(O_MEMORY_CYCLE_ENABLE_N, 80))
        else $error("read word not at cycle six");
    dev_decode_a: assert property (
        O_MEMORY_MAPPED_DEVICE_N != 8'hff |->
        O_ADDR[14:12] == MMD_REGION &&
        O_MEMORY_MAPPED_DEVICE_N == ~(8'h01 << O_ADDR[11:9]))
        else $error("mapped select decode wrong");
    sound_sel_a: assert property (
        !O_SOUND_BLOCK_ENABLE_N |->
        O_ADDR[14:9] == {MMD_REGION, SOUND_IDX})
        else $error("sound select outside its block");
    no_cart_a: assert property (!O_MEMORY_CYCLE_ENABLE_N |->
        O_ADDR[14:12] != CART_REGION)
        else $error("cartridge space reached");
endmodule

bind bsipc_top bsipc_properties u_props (.*);

/* File: bench/bsipc_periph_model.sv */
// Peripheral card model: byte read pattern, byte write capture, bit latch and bit input source
`timescale 1ns/10ps
module bsipc_periph_model #(
    parameter int LAT = 20
) (
    // Clock
    input  wire logic        i_clk,
    // Port pins
    input  wire logic [14:0] i_addr,
    input  wire logic        i_lsb,
    input  wire logic        i_mem_en_n,
    input  wire logic        i_rd_strobe,
    input  wire logic        i_wr_strobe_n,
    input  wire logic        i_bit_clk_n,
    input  wire logic [7:0]  i_bus,
    // Answers and captured values
    output logic [7:0]       o_data,
    output logic             o_bit_in,
    output logic [7:0]       o_wr_lo,
    output logic [7:0]       o_wr_hi,
    output logic [1:0]       o_wr_ord,
    output logic             o_bit_q,
    output logic [14:0]      o_bit_addr
);
    logic [16:0] key;
    int          age;

    initial o_data = 8'h00;
    initial key = 17'h00000;
    initial age = 0;

    // Read byte after access latency, churning pattern otherwise
    always @(posedge i_clk) begin
        age = ({i_mem_en_n, i_addr, i_lsb} != key) ? 0 : age + 1;
        key = {i_mem_en_n, i_addr, i_lsb};
        if (!i_mem_en_n && i_rd_strobe && i_addr[14:12] != 3'h3 &&
            age >= LAT) begin
            o_data <= i_addr[7:0] ^ (i_lsb ? 8'h3c : 8'hc3);
        end else begin
            o_data <= ~o_data;
        end
    end

    // Bit input follows the address at once
    assign o_bit_in = ^i_addr;

    // Byte write taken on the strobe's trailing edge
    always @(posedge i_wr_strobe_n) begin
        if (!i_mem_en_n) begin
            if (i_lsb) o_wr_lo <= i_bus;
            else o_wr_hi <= i_bus;
            o_wr_ord <= {o_wr_ord[0], i_lsb};
        end
    end

    // Output bit latched by the bit clock
    always @(posedge i_bit_clk_n) begin
        if (i_mem_en_n) begin
            o_bit_q <= i_lsb;
            o_bit_addr <= i_addr;
        end
    end
endmodule

/* File: bench/tb_byte_split_io_port_cycles.sv */
// Self-checking bench for the byte-split I/O port sequencer
`timescale 1ns/10ps
module tb_byte_split_io_port_cycles;
    import bsipc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, req = 1'b0, bh = 1'b0;
    bsipc_op_t   op = OP_READ;
    logic [15:0] addr = 16'h0000, wdata = 16'h0000, rdata;
    logic ready, done, bit_in, lsb, memory_cycle_enable_n_n, data_input_strobe, we_n, mbe_n, bclk_n;
    logic sbe_n, d_oe, p_bit, bit_q;
    logic [14:0] addr_o, bit_addr;
    logic [7:0]  mmd_n, d_out, d_in, p_data, wr_lo, wr_hi, sel_and;
    logic [1:0]  wr_ord;
    logic        mbe_lo, mem_lo;
    int          miscompares = 0, tests_run = 0;

    always #10 clk = ~clk;
    // Byte bus level from both parties
    assign d_in = d_oe ? d_out : p_data;

    bsipc_top u_dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_CPU_REQ(req),
        .I_CPU_OP(op), .I_CPU_ADDR(addr), .I_CPU_WDATA(wdata),
        .I_CPU_BYTE_HIGH(bh), .I_CPU_BIT(bh), .O_CPU_READY(ready),
        .O_CPU_DONE(done), .O_CPU_RDATA(rdata), .O_CPU_BIT_IN(bit_in),
        .O_ADDR(addr_o), .O_LSB_ADDRESS_OR_BIT_OUT(lsb),
        .O_MEMORY_CYCLE_ENABLE_N(memory_cycle_enable_n_n), .O_DATA_INPUT_STROBE(data_input_strobe),
        .O_WRITE_STROBE_N(we_n), .O_BLOCK_ENABLE_N(mbe_n),
        .O_BIT_IO_CLOCK_N(bclk_n), .O_MEMORY_MAPPED_DEVICE_N(mmd_n),
        .O_SOUND_BLOCK_ENABLE_N(sbe_n), .I_DATA(d_in), .O_DATA(d_out),
        .O_DATA_OE(d_oe), .I_BIT_IO_INPUT(p_bit));

    bsipc_periph_model #(.LAT(20)) u_card (.i_clk(clk), .i_addr(addr_o),
        .i_lsb(lsb), .i_mem_en_n(memory_cycle_enable_n_n), .i_rd_strobe(data_input_strobe),
        .i_wr_strobe_n(we_n), .i_bit_clk_n(bclk_n), .i_bus(d_in),
        .o_data(p_data), .o_bit_in(p_bit), .o_wr_lo(wr_lo), .o_wr_hi(wr_hi),
        .o_wr_ord(wr_ord), .o_bit_q(bit_q), .o_bit_addr(bit_addr));

    // Pin activity gathered over one operation
    always @(posedge clk) begin
        sel_and <= sel_and & mmd_n;
        mbe_lo <= mbe_lo | !mbe_n;
        mem_lo <= mem_lo | !memory_cycle_enable_n_n;
    end

    function automatic logic [7:0] pat(input logic [14:0] a, input logic l);
        return a[7:0] ^ (l ? 8'h3c : 8'hc3);
    endfunction

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One CPU request; n is the falling edge count until done
    task automatic run(input bsipc_op_t o, input logic [15:0] a,
                       input logic [15:0] w, input logic h, output int n);
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check("ready seen", 16'(ready), 16'h0001);
        sel_and = 8'hff;
        mbe_lo = 1'b0;
        mem_lo = 1'b0;
        op = o;
        addr = a;
        wdata = w;
        bh = h;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("done seen", 16'(done), 16'h0001);
    endtask

    task automatic t_read;
        int n;
        run(OP_READ, 16'h4003, 16'h0000, 1'b0, n);
        check("read word", rdata,
              {pat(15'h2001, 1'b0), pat(15'h2001, 1'b1)});
        check("read latency", 16'(n),
              16'(PRESENT_OFS) + 16'h0001);
        check("block enable", 16'(mbe_lo), 16'h0001);
        run(OP_READ, 16'h2ffe, 16'h0000, 1'b0, n);
        check("read word 2", rdata,
              {pat(15'h17ff, 1'b0), pat(15'h17ff, 1'b1)});
        check("no block enable", 16'(mbe_lo), 16'h0000);
    endtask

    task automatic t_write;
        int n;
        run(OP_WRITE_WORD, 16'h4010, 16'hbeef, 1'b0, n);
        check("word low", 16'(wr_lo), 16'h00ef);
        check("word high", 16'(wr_hi), 16'h00be);
        check("write order", 16'(wr_ord), 16'h0002);
        check("write latency", 16'(n),
              16'(2 * WORD_CLKS + CYC_CLKS + 1));
        for (int h = 0; h < 2; h++) begin
            run(OP_WRITE_BYTE, 16'h4021, 16'h77aa, h[0], n);
            check("byte high", 16'(wr_hi),
                  h ? 16'h0077 : 16'(pat(15'h2010, 1'b0)));
            check("byte low", 16'(wr_lo),
                  h ? 16'(pat(15'h2010, 1'b1)) : 16'h00aa);
        end
    endtask

    task automatic t_bits;
        int          n;
        logic [15:0] a;
        for (int b = 0; b < 2; b++) begin
            run(OP_BIT_OUT, 16'h1102 + 16'(4 * b), 16'h0000, b[0], n);
            check("bit latched", 16'(bit_q), 16'(b));
            check("bit address", 16'(bit_addr),
                  16'h0881 + 16'(2 * b));
            check("bit out time", 16'(n),
                  16'(BIT_CLKS) + 16'h0001);
            a = 16'h1106 + 16'(2 * b);
            run(OP_BIT_IN, a, 16'h0000, 1'b0, n);
            check("bit in", 16'(bit_in), 16'(^a[15:1]));
            check("bit in time", 16'(n),
                  16'(BIT_CLKS) + 16'h0001);
        end
    endtask

    task automatic t_map;
        int          n;
        logic [15:0] adr [4] = '{16'h8123, 16'h83f2, 16'h8400, 16'h9c00};
        logic [7:0]  sel [4] = '{8'hfe, 8'hfe, 8'hfd, 8'h7f};
        for (int i = 0; i < 4; i++) begin
            run(OP_READ, adr[i], 16'h0000, 1'b0, n);
            check("device select", 16'(sel_and),
                  16'(sel[i]));
        end
        run(OP_READ, 16'h6000, 16'h0000, 1'b0, n);
        check("refused data", rdata, REFUSED_DATA);
        check("refused pins", 16'(mem_lo), 16'h0000);
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check("idle pins", 16'({ready, done, memory_cycle_enable_n_n, data_input_strobe, we_n, mbe_n,
            bclk_n, d_oe}), 16'h00ae);
        t_read;
        t_write;
        t_bits;
        t_map;
        stop_test;
    end

    // Watchdog
    initial begin
        repeat (10000) @(posedge clk);
        miscompares++;
        stop_test;
    end
endmodule
